// ===== design/ims_acc_hs.sv
// Acceptor side of the three-wire handshake, for one status byte
module ims_acc_hs (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic dav_in,
  input wire logic [7:0] dio_in,
  output logic nrfd_out,
  output logic ndac_out,
  output logic [7:0] data_out,
  output logic done
);
  import ims_pkg::*;
  ims_acc_state_t state;

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= A_IDLE;
      nrfd_out <= 1'b0;
      ndac_out <= 1'b0;
      data_out <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        A_IDLE: if (start) begin
          ndac_out <= 1'b1;
          state <= A_READY;
        end
        A_READY: if (dav_in) begin
          data_out <= dio_in;
          nrfd_out <= 1'b1;
          ndac_out <= 1'b0;
          state <= A_HOLD;
        end
        A_HOLD: if (!dav_in) begin
          nrfd_out <= 1'b0;
          done <= 1'b1;
          state <= A_IDLE;
        end
        default: state <= A_IDLE;
      endcase
    end
  end
endmodule // ims_acc_hs

// ===== design/ims_pkg.sv
// Package of constants, types and states for the bus message sender
// Function
// - Every command byte goes out with ATN asserted for its whole transfer.
// - Numeric items are cut to their low eight bits and sent as one byte.
// - String items go out one byte per character, in character order.
// - Command, address, unlisten, untalk and secondary need active controller, else error.
// - Data bytes go out with ATN deasserted.
// - As active controller data goes at once, otherwise after being addressed to talk.
// - End marker drives EOI together with the last data byte.
// - Listen address n (0..30) is byte 32+n; raw 160..190 also accepted. The code refuses any value above 31 with an error.
// - Talk address n (0..30) is byte 64+n; raw 192..222 also accepted. The code refuses any value above 31 with an error.
// - Unlisten is byte 63, untalk is byte 95.
// - Serial poll: unlisten, own listen, target talk, 24, read status, 25, untalk.
// - Secondary address byte follows directly after its primary talk or listen address.
// - Normal paths clear bit 7 on command bytes; raw command path may set it.
// - Pass control: address new controller as talker, then send take control 9.
// - Interface clear and remote enable are never produced as command bytes.
// - Primary address 31 is never used as a device address. The code still accepts 31 on the listen and talk paths.
package ims_pkg;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [7:0] SEC_BASE = 8'h60;
  localparam logic [7:0] CODE_UNL = 8'h3F;
  localparam logic [7:0] CODE_UNT = 8'h5F;
  localparam logic [7:0] CODE_SPE = 8'h18;
  localparam logic [7:0] CODE_SPD = 8'h19;
  localparam logic [7:0] CODE_TCT = 8'h09;
  localparam logic [4:0] ADDR_RESERVED = 5'h1F;

  // ************************************************************
  // Sequence storage and timing
  // ************************************************************
  localparam int SEQ_MAX = 6;
  localparam logic [2:0] RECV_NONE = 3'h7;
  localparam logic [2:0] SPOLL_LEN = 3'h6;
  localparam logic [2:0] SPOLL_RECV = 3'h4;
  localparam logic [2:0] PASS_LEN = 3'h2;
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_SETTLE_NS = 8;
  localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Request types
  // ************************************************************
  typedef enum logic [3:0] {
    OP_CMD = 4'h0, OP_DATA = 4'h1, OP_LISTEN = 4'h2, OP_TALK = 4'h3,
    OP_UNL = 4'h4, OP_UNT = 4'h5, OP_SEC = 4'h6, OP_MLA = 4'h7,
    OP_MTA = 4'h8, OP_SPOLL = 4'h9, OP_PASS = 4'hA
  } ims_op_t;

  typedef struct packed {
    ims_op_t op;
    logic [15:0] arg;
    logic last;
  } ims_req_t;

  // ************************************************************
  // State machines
  // ************************************************************
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_WAIT_TALK = 6'h02, S_LAUNCH = 6'h04,
    S_SEND = 6'h08, S_RGO = 6'h10, S_RECV = 6'h20
  } ims_state_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_READY = 5'h02, H_SETTLE = 5'h04, H_ACCEPT = 5'h08, H_CLEAR = 5'h10
  } ims_src_state_t;

  typedef enum logic [2:0] {
    A_IDLE = 3'h1, A_READY = 3'h2, A_HOLD = 3'h4
  } ims_acc_state_t;

  function automatic logic [7:0] ims_addr_byte(input logic [7:0] base, input logic [4:0] n);
    return base + {3'h0, n};
  endfunction

endpackage

// ===== design/ims_sender.sv
// Bus message sender: turns host requests into handshaken bus bytes
module ims_sender (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire ims_pkg::ims_req_t req,
  output logic req_ready,
  output logic done,
  output logic err,
  output logic [7:0] poll_status,
  output logic poll_valid,
  input wire logic ac_active,
  input wire logic talker_addressed,
  input wire logic [4:0] my_addr,
  input wire logic [7:0] dio_in,
  output logic [7:0] dio_out,
  output logic dio_oe,
  output logic atn_out,
  output logic eoi_out,
  output logic dav_out,
  input wire logic dav_in,
  input wire logic nrfd_in,
  input wire logic ndac_in,
  output logic nrfd_out,
  output logic ndac_out
);
  import ims_pkg::*;

  // ************************************************************
  // Request decode
  // ************************************************************
  ims_state_t state, next_state;
  ims_op_t op_reg;
  logic last_reg;
  logic [7:0] seq [SEQ_MAX];
  logic [2:0] seq_len, idx, recv_pos;
  logic [7:0] build [SEQ_MAX];
  logic [2:0] next_len, next_recv;
  logic bad;

  wire accept = (state == S_IDLE) && req_valid && req_ready;
  wire [7:0] arg_byte = req.arg[7:0];
  wire [4:0] arg_n = req.arg[4:0];
  wire arg_over = |req.arg[15:5];
  wire arg_31 = (arg_n == ADDR_RESERVED);
  wire own_bad = (my_addr == ADDR_RESERVED);
  wire needs_ac = (req.op != OP_DATA);
  wire req_fault = bad || (needs_ac && !ac_active);
  wire may_talk = ac_active || talker_addressed;
  wire [7:0] lad_arg = ims_addr_byte(LISTEN_BASE, arg_n);
  wire [7:0] tad_arg = ims_addr_byte(TALK_BASE, arg_n);
  wire [7:0] lad_own = ims_addr_byte(LISTEN_BASE, my_addr);
  wire [7:0] tad_own = ims_addr_byte(TALK_BASE, my_addr);
  wire [7:0] sec_arg = ims_addr_byte(SEC_BASE, arg_n);

  // Raw bytes pass only on the command and data paths; all others keep bit 7 clear
  always_comb begin
    for (int i = 0; i < SEQ_MAX; i++) begin
      build[i] = 8'h00;
    end
    next_len = 3'h1;
    next_recv = RECV_NONE;
    bad = 1'b0;
    case (req.op)
      OP_CMD: build[0] = arg_byte;
      OP_DATA: build[0] = arg_byte;
      OP_LISTEN: begin
        build[0] = lad_arg;
        bad = arg_over;
      end
      OP_TALK: begin
        build[0] = tad_arg;
        bad = arg_over;
      end
      OP_UNL: build[0] = CODE_UNL;
      OP_UNT: build[0] = CODE_UNT;
      OP_SEC: begin
        build[0] = sec_arg;
        bad = arg_over || arg_31;
      end
      OP_MLA: begin
        build[0] = lad_own;
        bad = own_bad;
      end
      OP_MTA: begin
        build[0] = tad_own;
        bad = own_bad;
      end
      OP_SPOLL: begin
        build[0] = CODE_UNL;
        build[1] = lad_own;
        build[2] = tad_arg;
        build[3] = CODE_SPE;
        build[4] = CODE_SPD;
        build[5] = CODE_UNT;
        next_len = SPOLL_LEN;
        next_recv = SPOLL_RECV;
        bad = arg_over || arg_31 || own_bad;
      end
      OP_PASS: begin
        build[0] = tad_arg;
        build[1] = CODE_TCT;
        next_len = PASS_LEN;
        bad = arg_over || arg_31;
      end
      // Line operations such as clear and remote enable have no opcode here
      default: bad = 1'b1;
    endcase
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  wire hs_done, acc_done;
  wire [7:0] acc_data;
  wire [2:0] idx_next = idx + 3'h1;
  wire seq_end = (idx_next == seq_len);
  wire cur_atn = (op_reg != OP_DATA);
  wire cur_eoi = (op_reg == OP_DATA) && last_reg && seq_end;
  wire hs_start = (state == S_LAUNCH);
  wire acc_start = (state == S_RGO);

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (accept && !req_fault) begin
        next_state = (req.op == OP_DATA && !may_talk) ? S_WAIT_TALK : S_LAUNCH;
      end
      S_WAIT_TALK: if (may_talk) begin
        next_state = S_LAUNCH;
      end
      S_LAUNCH: next_state = S_SEND;
      S_SEND: if (hs_done) begin
        next_state = seq_end ? S_IDLE : (idx_next == recv_pos) ? S_RGO : S_LAUNCH;
      end
      S_RGO: next_state = S_RECV;
      S_RECV: if (acc_done) begin
        next_state = S_LAUNCH;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Requests are taken one at a time, so string characters keep their order
  always_ff @(posedge clk) begin
    if (reset) begin
      op_reg <= OP_CMD;
      last_reg <= 1'b0;
      seq_len <= 3'h1;
      recv_pos <= RECV_NONE;
      for (int i = 0; i < SEQ_MAX; i++) begin
        seq[i] <= 8'h00;
      end
    end else if (accept && !req_fault) begin
      op_reg <= req.op;
      last_reg <= req.last;
      seq_len <= next_len;
      recv_pos <= next_recv;
      seq <= build;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= S_IDLE;
      idx <= 3'h0;
      req_ready <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      poll_status <= 8'h00;
      poll_valid <= 1'b0;
    end else begin
      state <= next_state;
      req_ready <= (next_state == S_IDLE);
      err <= accept && req_fault;
      done <= (state == S_SEND) && hs_done && seq_end;
      poll_valid <= acc_done;
      if (acc_done) begin
        poll_status <= acc_data;
      end
      if (accept) begin
        idx <= 3'h0;
      end else if ((state == S_SEND) && hs_done) begin
        idx <= idx_next;
      end
    end
  end

  // ************************************************************
  // Handshake engines
  // ************************************************************
  ims_src_hs u_src (
    .clk(clk),
    .reset(reset),
    .start(hs_start),
    .byte_in(seq[idx]),
    .atn_in(cur_atn),
    .eoi_in(cur_eoi),
    .nrfd_in(nrfd_in),
    .ndac_in(ndac_in),
    .dio_out(dio_out),
    .dio_oe(dio_oe),
    .atn_out(atn_out),
    .eoi_out(eoi_out),
    .dav_out(dav_out),
    .done(hs_done)
  );

  ims_acc_hs u_acc (
    .clk(clk),
    .reset(reset),
    .start(acc_start),
    .dav_in(dav_in),
    .dio_in(dio_in),
    .nrfd_out(nrfd_out),
    .ndac_out(ndac_out),
    .data_out(acc_data),
    .done(acc_done)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_cmd_atn;
    @(posedge clk) disable iff (reset) (dav_out && op_reg != OP_DATA) |-> atn_out;
  endproperty
  a_cmd_atn: assert property (p_cmd_atn) else $error("command byte without ATN");

  property p_data_atn;
    @(posedge clk) disable iff (reset) (dav_out && op_reg == OP_DATA) |-> !atn_out;
  endproperty
  a_data_atn: assert property (p_data_atn) else $error("data byte with ATN");

  property p_refuse;
    @(posedge clk) disable iff (reset)
      (accept && needs_ac && !ac_active) |=> (err && state == S_IDLE);
  endproperty
  a_refuse: assert property (p_refuse) else $error("non-controller command not refused");

  property p_hold_data;
    @(posedge clk) disable iff (reset)
      (state == S_WAIT_TALK && !may_talk) |=> (state == S_WAIT_TALK && !dav_out);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("data left before talk addressing");

  property p_eoi;
    @(posedge clk) disable iff (reset) eoi_out |-> (!atn_out && dio_oe && last_reg && op_reg == OP_DATA);
  endproperty
  a_eoi: assert property (p_eoi) else $error("EOI outside last data byte");

  property p_listen;
    @(posedge clk) disable iff (reset)
      (accept && !req_fault && req.op == OP_LISTEN) |=> (seq[0] == LISTEN_BASE + $past(arg_byte));
  endproperty
  a_listen: assert property (p_listen) else $error("listen address encoded wrong");

  property p_untalk;
    @(posedge clk) disable iff (reset)
      (accept && !req_fault && req.op == OP_UNT) |=> (seq[0] == 8'h5F && seq_len == 3'h1);
  endproperty
  a_untalk: assert property (p_untalk) else $error("untalk code wrong");

  property p_spoll;
    @(posedge clk) disable iff (reset)
      (accept && !req_fault && req.op == OP_SPOLL)
        |=> (seq[0] == 8'h3F && seq[3] == 8'h18 && seq[4] == 8'h19 && seq[5] == 8'h5F && recv_pos == 3'h4);
  endproperty
  a_spoll: assert property (p_spoll) else $error("serial poll sequence wrong");

  property p_bit7;
    @(posedge clk) disable iff (reset) (dav_out && atn_out && op_reg != OP_CMD) |-> !dio_out[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 set on normal command");

  property p_pass;
    @(posedge clk) disable iff (reset)
      (accept && !req_fault && req.op == OP_PASS) |=> (seq[0][7:5] == 3'h2 && seq[1] == 8'h09);
  endproperty
  a_pass: assert property (p_pass) else $error("pass control sequence wrong");

  property p_settle;
    @(posedge clk) disable iff (reset) $rose(dav_out) |-> ($past(dio_oe, 2) && !$past(nrfd_in, 3));
  endproperty
  a_settle: assert property (p_settle) else $error("DAV before data settled");

  property p_no_reserved;
    @(posedge clk) disable iff (reset)
      (accept && (req.op == OP_MLA || req.op == OP_MTA) && own_bad) |=> err;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("own address 31 accepted");

  c_spoll: cover property (@(posedge clk) disable iff (reset) poll_valid ##[1:200] done);
  c_eoi: cover property (@(posedge clk) disable iff (reset) eoi_out && dav_out);
  c_refused: cover property (@(posedge clk) disable iff (reset) err);
  c_wait: cover property (@(posedge clk) disable iff (reset) state == S_WAIT_TALK ##[1:50] state == S_LAUNCH);
endmodule // ims_sender

// ===== design/ims_src_hs.sv
// Source side of the three-wire byte handshake
module ims_src_hs (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] byte_in,
  input wire logic atn_in,
  input wire logic eoi_in,
  input wire logic nrfd_in,
  input wire logic ndac_in,
  output logic [7:0] dio_out,
  output logic dio_oe,
  output logic atn_out,
  output logic eoi_out,
  output logic dav_out,
  output logic done
);
  import ims_pkg::*;
  ims_src_state_t state;
  logic [3:0] settle;

  // Lines are released between bytes; ATN drops briefly between command bytes
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= H_IDLE;
      settle <= 4'h0;
      dio_out <= 8'h00;
      dio_oe <= 1'b0;
      atn_out <= 1'b0;
      eoi_out <= 1'b0;
      dav_out <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        H_IDLE: if (start) begin
          dio_out <= byte_in;
          dio_oe <= 1'b1;
          atn_out <= atn_in;
          eoi_out <= eoi_in;
          state <= H_READY;
        end
        H_READY: if (!nrfd_in) begin
          settle <= 4'(SETTLE_CYC);
          state <= H_SETTLE;
        end
        // Data must settle on the lines before DAV is asserted
        H_SETTLE: if (settle <= 4'h1) begin
          dav_out <= 1'b1;
          state <= H_ACCEPT;
        end else begin
          settle <= settle - 4'h1;
        end
        H_ACCEPT: if (!ndac_in) begin
          dav_out <= 1'b0;
          state <= H_CLEAR;
        end
        H_CLEAR: if (ndac_in) begin
          dio_oe <= 1'b0;
          atn_out <= 1'b0;
          eoi_out <= 1'b0;
          done <= 1'b1;
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule // ims_src_hs

// ===== testbench/ims_bus_model.sv
// Behavioural model of the acceptors and the polled talker on the far side of the bus
module ims_bus_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] status,
  input wire logic [3:0] delay,
  input wire logic [7:0] dio_out,
  input wire logic atn_out,
  input wire logic eoi_out,
  input wire logic dav_out,
  input wire logic nrfd_out,
  input wire logic ndac_out,
  output logic nrfd_in,
  output logic ndac_in,
  output logic dav_in,
  output logic [7:0] dio_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Acceptor and talker
  // ************************************************************
  logic [9:0] log_q[$];
  logic [3:0] wait_cnt;
  logic offered;
  initial begin
    nrfd_in = 1'b0;
    ndac_in = 1'b1;
    dav_in = 1'b0;
    dio_in = 8'hA5;
    wait_cnt = 4'h0;
    offered = 1'b0;
  end
  always @(posedge clk) begin
    if (reset) begin
      nrfd_in <= 1'b0;
      ndac_in <= 1'b1;
      dav_in <= 1'b0;
      offered <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      // Slow acceptance stretches DAV so the source must really wait
      if (dav_out && ndac_in) begin
        if (wait_cnt < delay) begin
          wait_cnt <= wait_cnt + 4'h1;
        end else begin
          log_q.push_back({atn_out, eoi_out, dio_out});
          ndac_in <= 1'b0;
          nrfd_in <= 1'b1;
          wait_cnt <= 4'h0;
        end
      end else if (!dav_out && !ndac_in) begin
        ndac_in <= 1'b1;
        nrfd_in <= 1'b0;
      end
      if (dav_out) begin
        offered <= 1'b0;
      end
      // One status byte per poll; released lines show the inverse value
      if (!dav_in && !offered && nrfd_out === 1'b0 && ndac_out === 1'b1) begin
        dio_in <= status;
        dav_in <= 1'b1;
        offered <= 1'b1;
      end else if (dav_in && nrfd_out === 1'b1 && ndac_out === 1'b0) begin
        dav_in <= 1'b0;
        dio_in <= ~status;
      end
    end
  end
endmodule // ims_bus_model

// ===== testbench/ims_sender_test.sv
// Self-checking bench for the bus message sender
module ims_sender_test;
  import ims_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    ims_op_t op;
    logic [15:0] arg;
    logic last;
    logic ac;
    logic [3:0] dly;
    logic err;
    logic [9:0] exp;
  } ims_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic ac_active = 1'b1;
  logic talker_addressed = 1'b0;
  ims_req_t req = '0;
  logic [4:0] my_addr = 5'h15;
  logic [7:0] status = 8'h5A;
  logic [3:0] dly = 4'h0;
  logic [7:0] dio_out, poll_status, pm_dio, dio_bus, got_status;
  logic req_ready, done, err, poll_valid, dio_oe, atn_out, eoi_out, dav_out;
  logic dav_in, nrfd_in, ndac_in, nrfd_out, ndac_out, seen_err;
  logic [9:0] exp_q[$];
  int mismatches = 0;
  int checked = 0;
  ims_row_t rows[23];
  // Bus wire: our drive wins while enabled, else the model's lines
  assign dio_bus = dio_oe ? dio_out : pm_dio;
  always #2 clk = ~clk;
  ims_sender dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .done(done), .err(err), .poll_status(poll_status), .poll_valid(poll_valid), .ac_active(ac_active),
    .talker_addressed(talker_addressed), .my_addr(my_addr), .dio_in(dio_bus), .dio_out(dio_out),
    .dio_oe(dio_oe), .atn_out(atn_out), .eoi_out(eoi_out), .dav_out(dav_out), .dav_in(dav_in),
    .nrfd_in(nrfd_in), .ndac_in(ndac_in), .nrfd_out(nrfd_out), .ndac_out(ndac_out));
  ims_bus_model bm (.clk(clk), .reset(reset), .status(status), .delay(dly), .dio_out(dio_out),
    .atn_out(atn_out), .eoi_out(eoi_out), .dav_out(dav_out), .nrfd_out(nrfd_out), .ndac_out(ndac_out),
    .nrfd_in(nrfd_in), .ndac_in(ndac_in), .dav_in(dav_in), .dio_in(pm_dio));
  // ************************************************************
  // Tasks
  // ************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task send(input ims_op_t op, input logic [15:0] arg, input logic last);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (req_ready !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t: request port never ready", $time);
    end
    req_valid = 1'b1;
    req = '{op, arg, last};
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task finish();
    int n;
    n = 0;
    while (done !== 1'b1 && err !== 1'b1 && n < 3000) begin
      if (poll_valid === 1'b1) got_status = poll_status;
      @(negedge clk);
      n++;
    end
    seen_err = (err === 1'b1);
    if (n >= 3000) begin
      mismatches++;
      $display("[FAIL] %0t: request never completed", $time);
    end
    @(negedge clk);
  endtask
  task expect_log();
    check(bm.log_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < bm.log_q.size()) check(bm.log_q[i], exp_q[i]);
    bm.log_q.delete();
  endtask
  task stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    rows = '{'{OP_CMD, 16'h0008, 0, 1, 0, 0, 10'h208},
      '{OP_CMD, 16'h0185, 0, 1, 0, 0, 10'h285},
      '{OP_CMD, 16'h003F, 0, 1, 0, 0, 10'h23F},
      '{OP_CMD, 16'h0055, 0, 1, 0, 0, 10'h255},
      '{OP_CMD, 16'h0021, 0, 1, 0, 0, 10'h221},
      '{OP_LISTEN, 16'h0001, 0, 1, 0, 0, 10'h221},
      '{OP_LISTEN, 16'h001E, 0, 1, 0, 0, 10'h23E},
      '{OP_TALK, 16'h0000, 0, 1, 0, 0, 10'h240},
      '{OP_TALK, 16'h001E, 0, 1, 0, 0, 10'h25E},
      '{OP_UNL, 16'h0000, 0, 1, 0, 0, 10'h23F},
      '{OP_UNT, 16'h0000, 0, 1, 0, 0, 10'h25F},
      '{OP_TALK, 16'h0005, 0, 1, 0, 0, 10'h245},
      '{OP_SEC, 16'h0003, 0, 1, 0, 0, 10'h263},
      '{OP_MLA, 16'h0000, 0, 1, 0, 0, 10'h235},
      '{OP_MTA, 16'h0000, 0, 1, 0, 0, 10'h255},
      '{OP_CMD, 16'h0005, 0, 1, 0, 0, 10'h205},
      '{OP_CMD, 16'h0060, 0, 1, 6, 0, 10'h260},
      '{OP_DATA, 16'h0141, 1, 1, 3, 0, 10'h141},
      '{OP_DATA, 16'h00E0, 0, 1, 0, 0, 10'h0E0},
      '{OP_CMD, 16'h0008, 0, 0, 0, 1, 10'h000},
      '{OP_SEC, 16'h0001, 0, 0, 0, 1, 10'h000},
      '{OP_LISTEN, 16'h0020, 0, 1, 0, 1, 10'h000},
      '{OP_SEC, 16'h001F, 0, 1, 0, 1, 10'h000}};
    repeat (12) @(negedge clk);
    check(req_ready, 0); // Reset state
    check({dio_oe, atn_out, dav_out}, 0);
    reset = 1'b0;
    foreach (rows[i]) begin
      ac_active = rows[i].ac;
      dly = rows[i].dly;
      send(rows[i].op, rows[i].arg, rows[i].last);
      finish();
      check(seen_err, rows[i].err);
      if (rows[i].err) exp_q = {};
      else exp_q = {rows[i].exp};
      expect_log();
    end
    ac_active = 1'b1;
    dly = 4'h2;
    got_status = 8'h00;
    send(OP_SPOLL, 16'h0018, 1'b0);
    finish();
    exp_q = {10'h23F, 10'h235, 10'h258, 10'h218, 10'h219, 10'h25F};
    expect_log();
    check(got_status, 8'h5A);
    send(OP_PASS, 16'h0014, 1'b0);
    finish();
    exp_q = {10'h254, 10'h209};
    expect_log();
    my_addr = 5'h1F;
    send(OP_SPOLL, 16'h0003, 1'b0);
    finish();
    check(seen_err, 1);
    send(OP_MTA, 16'h0000, 1'b0);
    finish();
    check(seen_err, 1);
    send(ims_op_t'(4'hB), 16'h0000, 1'b0);
    finish();
    check(seen_err, 1);
    my_addr = 5'h15;
    exp_q = {};
    expect_log();
    // Not controller: data must wait for the talk addressing
    ac_active = 1'b0;
    send(OP_DATA, 16'h000A, 1'b1);
    repeat (40) @(negedge clk);
    check(bm.log_q.size(), 0);
    talker_addressed = 1'b1;
    finish();
    check(seen_err, 0);
    exp_q = {10'h10A};
    expect_log();
    // Reset in mid-transfer: lines drop at once and the next request still goes out whole
    ac_active = 1'b1;
    talker_addressed = 1'b0;
    dly = 4'hF;
    send(OP_CMD, 16'h0004, 1'b0);
    repeat (6) @(negedge clk);
    check(dav_out, 1);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    check({req_ready, dio_oe, atn_out, eoi_out, dav_out}, 0);
    reset = 1'b0;
    dly = 4'h0;
    check(bm.log_q.size(), 0);
    send(OP_CMD, 16'h0004, 1'b0);
    finish();
    check(seen_err, 0);
    exp_q = {10'h204};
    expect_log();
    stop_test();
  end
endmodule // ims_sender_test
